// >>> rtl/pci_bus_agent.sv
`timescale 1ns/1ps
module pci_bus_agent (
    input  wire logic                          clock,
    input  wire logic                          rstn,
    input  wire logic [trace_pkg::AD_W-1:0]    ad_value,
    input  wire logic [trace_pkg::CTRL_W-1:0]  ctrl_value,
    pci_obs_if.agent                           bus
);
    import trace_pkg::*;

    logic [DIV_W-1:0]  div_q;
    logic [DIV_W-1:0]  div_d;
    logic              clk_q;
    logic              clk_d;
    logic [AD_W-1:0]   ad_q;
    logic [AD_W-1:0]   ad_d;
    logic [CTRL_W-1:0] ctrl_q;
    logic [CTRL_W-1:0] ctrl_d;

    // lines change on the falling edge so they are settled at the rising one
    always_comb begin
        div_d  = div_q + DIV_W'(1);
        clk_d  = clk_q;
        ad_d   = ad_q;
        ctrl_d = ctrl_q;
        if (div_q == DIV_W'(PCI_HALF - 1)) begin
            div_d = '0;
            clk_d = ~clk_q;
            if (clk_q) begin
                ad_d   = ad_value;
                ctrl_d = ctrl_value;
            end
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            div_q  <= '0;
            clk_q  <= 1'b0;
            ad_q   <= '0;
            ctrl_q <= '0;
        end else begin
            div_q  <= div_d;
            clk_q  <= clk_d;
            ad_q   <= ad_d;
            ctrl_q <= ctrl_d;
        end
    end

    assign bus.pci_clk = clk_q;
    assign bus.ad      = ad_q;
    assign bus.ctrl    = ctrl_q;
endmodule

// >>> rtl/pci_obs_if.sv
`timescale 1ns/1ps
interface pci_obs_if;
    import trace_pkg::*;
    logic                pci_clk;
    logic [AD_W-1:0]     ad;
    logic [CTRL_W-1:0]   ctrl;

    modport agent (output pci_clk, output ad, output ctrl);
    modport tracer (input pci_clk, input ad, input ctrl);
endinterface

// >>> rtl/pci_trace_buffer.sv
// Overview of operation
// - status bit 14 reads one while running
// - bits 11:4 give log2 of entries
// - write one to bit 1 stops tracing
// - write one to bit 0 starts, arms
// - mode 00 is continuous; others reserved
// - disarm after trigger count matches seen
// - store post count entries, then stop
// - software keeps post count below size-2
// - 32-bit AD pattern compared with lines
// - AD mask zero bit always matches
// - control pattern bits 19:3 compared
// - control mask zero bit always matches
// - readable sampled AD lines
// - readable sampled control lines, same layout
// - status bit 15 reads one while armed
// - bits 31:16 give first entry index
`timescale 1ns/1ps
module pci_trace_buffer (
    input  wire logic                           clock,
    input  wire logic                           rstn,
    input  wire logic                           psel,
    input  wire logic                           penable,
    input  wire logic                           pwrite,
    input  wire logic [trace_pkg::ADDR_W-1:0]   paddr,
    input  wire logic [31:0]                    pwdata,
    output logic      [31:0]                    prdata,
    output logic                                pready,
    output logic                                pslverr,
    pci_obs_if.tracer                           bus
);
    import trace_pkg::*;
    // link synchronisers: stage 1 feeds only stage 2
    logic               clk_s1;
    logic               clk_s2;
    logic               clk_s3;
    logic [AD_W-1:0]    ad_s1;
    logic [AD_W-1:0]    ad_s2;
    logic [CTRL_W-1:0]  ctrl_s1;
    logic [CTRL_W-1:0]  ctrl_s2;
    logic [AD_W-1:0]    ad_st_q;
    logic [AD_W-1:0]    ad_st_d;
    logic [CTRL_W-1:0]  ctrl_st_q;
    logic [CTRL_W-1:0]  ctrl_st_d;
    logic               sample;
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            clk_s1  <= 1'b0;
            clk_s2  <= 1'b0;
            clk_s3  <= 1'b0;
            ad_s1   <= '0;
            ad_s2   <= '0;
            ctrl_s1 <= '0;
            ctrl_s2 <= '0;
        end else begin
            clk_s1  <= bus.pci_clk;
            clk_s2  <= clk_s1;
            clk_s3  <= clk_s2;
            ad_s1   <= bus.ad;
            ad_s2   <= ad_s1;
            ctrl_s1 <= bus.ctrl;
            ctrl_s2 <= ctrl_s1;
        end
    end
    assign sample = clk_s2 & ~clk_s3;
    // software registers
    logic [3:0]         mode_q, mode_d;
    logic [7:0]         trig_q, trig_d;
    logic [15:0]        post_q, post_d;
    logic [AD_W-1:0]    adpat_q, adpat_d;
    logic [AD_W-1:0]    admask_q, admask_d;
    logic [CTRL_W-1:0]  cpat_q, cpat_d;
    logic [CTRL_W-1:0]  cmask_q, cmask_d;
    logic [PTR_W-1:0]   rdidx_q, rdidx_d;
    // capture engine
    trace_state_t       state_q, state_d;
    logic [PTR_W-1:0]   wptr_q, wptr_d;
    logic [7:0]         hits_q, hits_d;
    logic [15:0]        pcnt_q, pcnt_d;
    logic [PTR_W-1:0]   first_q, first_d;
    logic [ENTRY_W-1:0] mem_q [DEPTH];
    logic               mem_we;
    // bus answer
    logic [31:0]        prdata_q, prdata_d;
    logic               pready_q, pready_d;
    logic               pslverr_q, pslverr_d;
    logic               wr_commit;
    logic               match;
    logic [31:0]        csr_word;
    assign wr_commit = psel & penable & pwrite & pready_q;
    // unmasked bits must all agree, AD and control together
    assign match = (&(~(ad_s2 ^ adpat_q) | ~admask_q))
                 & (&(~(ctrl_s2 ^ cpat_q) | ~cmask_q));
    assign csr_word = {16'(first_q), (state_q == ST_ARMED),
                       (state_q != ST_IDLE), 2'b00,
                       8'(DEPTH_EXP), 4'h0};
    always_comb begin
        mode_d   = mode_q;
        trig_d   = trig_q;
        post_d   = post_q;
        adpat_d  = adpat_q;
        admask_d = admask_q;
        cpat_d   = cpat_q;
        cmask_d  = cmask_q;
        rdidx_d  = rdidx_q;
        if (wr_commit) begin
            if (paddr == OFF_CNT_MODE) begin
                mode_d = pwdata[CM_MODE_LO +: 4];
                trig_d = pwdata[CM_TRIG_LO +: 8];
                post_d = pwdata[CM_POST_LO +: 16];
            end else if (paddr == OFF_AD_PAT) begin
                adpat_d = pwdata;
            end else if (paddr == OFF_AD_MASK) begin
                admask_d = pwdata;
            end else if (paddr == OFF_CTRL_PAT) begin
                cpat_d = pwdata[CTRL_LO +: CTRL_W];
            end else if (paddr == OFF_CTRL_MASK) begin
                cmask_d = pwdata[CTRL_LO +: CTRL_W];
            end else if (paddr == OFF_RD_INDEX) begin
                rdidx_d = pwdata[PTR_W-1:0];
            end
        end
    end
    // only continuous sampling exists; reserved modes behave the same
    always_comb begin
        state_d = state_q;
        wptr_d  = wptr_q;
        hits_d  = hits_q;
        pcnt_d  = pcnt_q;
        first_d = first_q;
        mem_we  = 1'b0;
        case (state_q)
            ST_ARMED: begin
                if (sample) begin
                    mem_we = 1'b1;
                    wptr_d = wptr_q + PTR_W'(1);
                    if (match) begin
                        hits_d = hits_q + 8'h01;
                        if ({1'b0, hits_q} + 9'h001 >= {1'b0, trig_q}) begin
                            state_d = ST_POST;
                            pcnt_d  = 16'h0000;
                            if (post_q == 16'h0000) begin
                                state_d = ST_IDLE;
                                first_d = wptr_q + PTR_W'(1);
                            end
                        end
                    end
                end
            end
            ST_POST: begin
                if (sample) begin
                    mem_we = 1'b1;
                    wptr_d = wptr_q + PTR_W'(1);
                    pcnt_d = pcnt_q + 16'h0001;
                    if ({1'b0, pcnt_q} + 17'h00001 >= {1'b0, post_q}) begin
                        state_d = ST_IDLE;
                        first_d = wptr_q + PTR_W'(1);
                    end
                end
            end
            default: begin
            end
        endcase
        // a command write overrides the sample path; stop wins over start
        if (wr_commit && paddr == OFF_CSR) begin
            if (pwdata[CSR_STOP]) begin
                if (state_q != ST_IDLE) begin
                    state_d = ST_IDLE;
                    first_d = wptr_d;
                end
            end else if (pwdata[CSR_START]) begin
                state_d = ST_ARMED;
                hits_d  = 8'h00;
                pcnt_d  = 16'h0000;
            end
        end
    end
    always_comb begin
        ad_st_d   = ad_st_q;
        ctrl_st_d = ctrl_st_q;
        if (sample) begin
            ad_st_d   = ad_s2;
            ctrl_st_d = ctrl_s2;
        end
    end
    // two-cycle access: answer registered one cycle after the setup ends
    always_comb begin
        prdata_d  = prdata_q;
        pready_d  = psel & penable & ~pready_q;
        pslverr_d = 1'b0;
        if (psel && penable && !pready_q) begin
            prdata_d = RESET_WORD;
            if (paddr == OFF_CSR) begin
                prdata_d = pwrite ? RESET_WORD : csr_word;
            end else if (paddr == OFF_CNT_MODE) begin
                prdata_d = {4'h0, mode_q, trig_q, post_q};
            end else if (paddr == OFF_AD_PAT) begin
                prdata_d = adpat_q;
            end else if (paddr == OFF_AD_MASK) begin
                prdata_d = admask_q;
            end else if (paddr == OFF_CTRL_PAT) begin
                prdata_d = {12'h000, cpat_q, 3'h0};
            end else if (paddr == OFF_CTRL_MASK) begin
                prdata_d = {12'h000, cmask_q, 3'h0};
            end else if (paddr == OFF_AD_STATE) begin
                prdata_d = ad_st_q;
            end else if (paddr == OFF_CTRL_ST) begin
                prdata_d = {12'h000, ctrl_st_q, 3'h0};
            end else if (paddr == OFF_RD_INDEX) begin
                prdata_d = {24'h000000, rdidx_q};
            end else if (paddr == OFF_RD_AD) begin
                prdata_d = mem_q[rdidx_q][AD_W-1:0];
            end else if (paddr == OFF_RD_CTRL) begin
                prdata_d = {12'h000, mem_q[rdidx_q][ENTRY_W-1:AD_W], 3'h0};
            end else begin
                pslverr_d = 1'b1;
            end
        end
    end
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            mode_q    <= MODE_CONT;
            trig_q    <= '0;
            post_q    <= '0;
            adpat_q   <= '0;
            admask_q  <= '0;
            cpat_q    <= '0;
            cmask_q   <= '0;
            rdidx_q   <= '0;
            state_q   <= ST_IDLE;
            wptr_q    <= '0;
            hits_q    <= '0;
            pcnt_q    <= '0;
            first_q   <= '0;
            ad_st_q   <= '0;
            ctrl_st_q <= '0;
            prdata_q  <= '0;
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
        end else begin
            mode_q    <= mode_d;
            trig_q    <= trig_d;
            post_q    <= post_d;
            adpat_q   <= adpat_d;
            admask_q  <= admask_d;
            cpat_q    <= cpat_d;
            cmask_q   <= cmask_d;
            rdidx_q   <= rdidx_d;
            state_q   <= state_d;
            wptr_q    <= wptr_d;
            hits_q    <= hits_d;
            pcnt_q    <= pcnt_d;
            first_q   <= first_d;
            ad_st_q   <= ad_st_d;
            ctrl_st_q <= ctrl_st_d;
            prdata_q  <= prdata_d;
            pready_q  <= pready_d;
            pslverr_q <= pslverr_d;
        end
    end
    // trace memory wraps naturally at the pointer width
    always_ff @(posedge clock) begin
        if (mem_we) begin
            mem_q[wptr_q] <= {ctrl_s2, ad_s2};
        end
    end
    assign prdata  = prdata_q;
    assign pready  = pready_q;
    assign pslverr = pslverr_q;
endmodule

// >>> rtl/trace_pkg.sv
package trace_pkg;
    localparam int             AD_W          = 32;
    localparam int             CTRL_W        = 17;
    localparam int             DEPTH_EXP     = 8;
    localparam int             DEPTH         = 1 << DEPTH_EXP;
    localparam int             ENTRY_W       = AD_W + CTRL_W;
    localparam int             PTR_W         = DEPTH_EXP;
    localparam int             ADDR_W        = 8;
    // register byte offsets
    localparam logic [7:0]     OFF_CSR       = 8'h80;
    localparam logic [7:0]     OFF_CNT_MODE  = 8'h84;
    localparam logic [7:0]     OFF_AD_PAT    = 8'h88;
    localparam logic [7:0]     OFF_AD_MASK   = 8'h8C;
    localparam logic [7:0]     OFF_CTRL_PAT  = 8'h90;
    localparam logic [7:0]     OFF_CTRL_MASK = 8'h94;
    localparam logic [7:0]     OFF_AD_STATE  = 8'h98;
    localparam logic [7:0]     OFF_CTRL_ST   = 8'h9C;
    localparam logic [7:0]     OFF_RD_INDEX  = 8'hA0;
    localparam logic [7:0]     OFF_RD_AD     = 8'hA4;
    localparam logic [7:0]     OFF_RD_CTRL   = 8'hA8;
    // control/status fields
    localparam int             CSR_START     = 0;
    localparam int             CSR_STOP      = 1;
    localparam int             CSR_DEPTH_LO  = 4;
    localparam int             CSR_RUN       = 14;
    localparam int             CSR_ARMED     = 15;
    localparam int             CSR_INDEX_LO  = 16;
    // counter/mode fields
    localparam int             CM_POST_LO    = 0;
    localparam int             CM_TRIG_LO    = 16;
    localparam int             CM_MODE_LO    = 24;
    localparam logic [3:0]     MODE_CONT     = 4'h0;
    // control lines sit at bits 19:3 of their registers
    localparam int             CTRL_LO       = 3;
    localparam logic [31:0]    RESET_WORD    = 32'h0000_0000;
    // agent: half period of the generated bus clock in system cycles
    localparam int             PCI_HALF      = 6;
    localparam int             DIV_W         = 4;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_ARMED = 3'b010,
        ST_POST  = 3'b100
    } trace_state_t;
endpackage

// >>> verif/pci_bus_trace_props.sv
`timescale 1ns/1ps
module pci_bus_trace_props (
    input wire logic                         clock,
    input wire logic                         rstn,
    input wire logic                         psel,
    input wire logic                         penable,
    input wire logic                         pwrite,
    input wire logic [trace_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0]                  prdata,
    input wire logic                         pready,
    input wire logic                         pslverr,
    input wire logic                         pci_clk,
    input wire logic [trace_pkg::AD_W-1:0]   ad,
    input wire logic [trace_pkg::CTRL_W-1:0] ctrl
);
    import trace_pkg::*;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);

    clk_high_a: assert property ($rose(pci_clk) |-> pci_clk [*6] ##1 !pci_clk)
        else $error("bus clock high phase wrong");
    clk_low_a: assert property ($fell(pci_clk) |-> !pci_clk [*6] ##1 pci_clk)
        else $error("bus clock low phase wrong");
    // data may only move while the bus clock is low, so the device sees it settled
    data_hold_a: assert property (pci_clk |-> $stable(ad) && $stable(ctrl))
        else $error("bus lines moved while clock high");
    one_wait_a: assert property ($rose(penable) && psel |-> !pready ##1 pready)
        else $error("apb answer not after one wait state");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("apb ready longer than one cycle");
    err_ready_a: assert property (pslverr |-> pready && psel && penable)
        else $error("error without ready");
    map_err_a: assert property (pready && paddr[1:0] == 2'h0 |->
        pslverr == (paddr < OFF_CSR || paddr > OFF_RD_CTRL))
        else $error("error flag disagrees with address map");
    err_zero_a: assert property (pslverr && !pwrite |-> prdata == 32'h0000_0000)
        else $error("refused read returned data");

    cover property ($rose(pci_clk));
    cover property (pslverr);
    cover property (pready && !pwrite && paddr == OFF_CSR);
endmodule

// >>> verif/test_pci_bus_trace_buffer.sv
`timescale 1ns/1ps
module test_pci_bus_trace_buffer;
    import trace_pkg::*;
    logic              clock;
    logic              rstn;
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0]       pwdata;
    logic [31:0]       prdata;
    logic              pready;
    logic              pslverr;
    logic [AD_W-1:0]   ad_value;
    logic [CTRL_W-1:0] ctrl_value;
    logic [31:0]       rd;
    logic              er;
    logic [7:0]        idx;
    int                fail_count;
    int                comparisons;
    int                cycles;
    localparam logic [CTRL_W-1:0] GOOD = 17'h0_0F0F;
    localparam logic [CTRL_W-1:0] BAD  = 17'h0_0F0E;

    pci_obs_if bus_if ();
    pci_bus_agent pci_bus_agent_i (.clock(clock), .rstn(rstn), .ad_value(ad_value),
        .ctrl_value(ctrl_value), .bus(bus_if.agent));
    pci_trace_buffer pci_trace_buffer_i (.clock(clock), .rstn(rstn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .bus(bus_if.tracer));
    pci_bus_trace_props pci_bus_trace_props_i (.clock(clock), .rstn(rstn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .pci_clk(bus_if.pci_clk), .ad(bus_if.ad),
        .ctrl(bus_if.ctrl));

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    task automatic wrap_up();
        $display("comparisons=%0d fail_count=%0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // hang guard: the whole sequence needs well under two thousand cycles
    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            wrap_up();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic wr_en, input logic [7:0] a, input logic [31:0] wd);
        @(posedge clock);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr_en;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge clock);
        penable <= 1'b1;
        do @(posedge clock); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m);
        apb(1'b0, a, 32'h0000_0000);
        chk(rd & m, exp & m);
    endtask

    initial begin
        rstn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
        pwdata = 32'h0000_0000; ad_value = 32'h0000_0000; ctrl_value = 17'h0_0000;
        repeat (5) @(posedge clock);
        rstn <= 1'b1;
        rdc(OFF_CSR, 32'h0000_0080, 32'h0000_CFF0);
        // post count kept well below the buffer size minus two
        for (int i = 0; i < 5; i++) begin
            apb(1'b1, 8'h84 + 8'(4 * i), 32'h00C3_005A + 32'(i));
            rdc(8'h84 + 8'(4 * i), 32'h00C3_005A + 32'(i),
                (i == 0) ? 32'h0FFF_FFFF : (i > 2) ? 32'h000F_FFF8 : 32'hFFFF_FFFF);
        end
        apb(1'b0, 8'h40, 32'h0000_0000);
        chk({rd[30:0], er}, 32'h0000_0001);
        apb(1'b1, OFF_AD_STATE, 32'hFFFF_FFFF);
        chk({31'h0, er}, 32'h0000_0000);
        ad_value <= 32'hA5C3_0F1E;
        ctrl_value <= 17'h1_2345;
        repeat (40) @(posedge clock);
        rdc(OFF_AD_STATE, 32'hA5C3_0F1E, 32'hFFFF_FFFF);
        rdc(OFF_CTRL_ST, {12'h0, 17'h1_2345, 3'h0}, 32'h000F_FFF8);
        apb(1'b1, OFF_AD_PAT, 32'hCAFE_0000);
        apb(1'b1, OFF_AD_MASK, 32'hFFFF_0000);
        apb(1'b1, OFF_CTRL_PAT, {12'h0, GOOD, 3'h0});
        apb(1'b1, OFF_CTRL_MASK, 32'h000F_FFF8);
        apb(1'b1, OFF_CNT_MODE, 32'h0002_0003);
        ad_value <= 32'h1234_5678;
        ctrl_value <= GOOD;
        apb(1'b1, OFF_CSR, 32'h0000_0001);
        repeat (40) @(posedge clock);
        rdc(OFF_CSR, 32'h0000_C000, 32'h0000_C000);
        ad_value <= 32'hCAFE_1111;
        ctrl_value <= BAD;
        repeat (40) @(posedge clock);
        rdc(OFF_CSR, 32'h0000_C000, 32'h0000_C000);
        ctrl_value <= GOOD;
        for (int n = 0; n < 60 && rd[14] !== 1'b0; n++) begin
            apb(1'b0, OFF_CSR, 32'h0000_0000);
        end
        chk(rd & 32'h0000_C000, 32'h0000_0000);
        idx = rd[23:16];
        // two matches then three more: five matching entries behind the index
        apb(1'b1, OFF_RD_INDEX, {24'h0, idx - 8'h01});
        rdc(OFF_RD_AD, 32'hCAFE_1111, 32'hFFFF_FFFF);
        apb(1'b1, OFF_RD_INDEX, {24'h0, idx - 8'h05});
        rdc(OFF_RD_CTRL, {12'h0, GOOD, 3'h0}, 32'h000F_FFF8);
        apb(1'b1, OFF_RD_INDEX, {24'h0, idx - 8'h06});
        rdc(OFF_RD_CTRL, {12'h0, BAD, 3'h0}, 32'h000F_FFF8);
        apb(1'b1, OFF_CSR, 32'h0000_0001);
        rdc(OFF_CSR, 32'h0000_C000, 32'h0000_C000);
        apb(1'b1, OFF_CSR, 32'h0000_0002);
        rdc(OFF_CSR, 32'h0000_0000, 32'h0000_C000);
        apb(1'b1, OFF_CSR, 32'h0000_0003);
        rdc(OFF_CSR, 32'h0000_0000, 32'h0000_C000);
        wrap_up();
    end
endmodule
